//--- rtl/sac_top.sv
/*
 * Conversion control and three-wire serial readout of a 12-bit sampling converter.
 * Assumes the analog front end presents its code on the system clock; the shift clock
 * and convert strobe come from the outside controller and are asynchronous to it.
 */
`timescale 1ns/10ps
module sac_top
   import sac_pkg::*;
#(
   parameter sac_grade_t GRADE = GRADE_FAST
)
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_sck,
   input wire logic i_convert_strobe,
   input wire logic [RES_W-1:0] i_ain_code,
   output logic o_serial_result_out,
   output logic o_serial_result_out_oe_n,
   output logic o_powered,
   output logic o_track,
   output logic o_busy
);

   localparam int CONVERT_STROBE_CYC = convert_strobe_cycles(GRADE);
   localparam int STEP_CYC = CONVERT_STROBE_CYC / RES_W;

   sac_sar_if sar_bus();

   sac_state_t state_reg;
   sac_state_t state_next;
   logic convert_strobe_meta_reg;
   logic convert_strobe_sync_reg;
   logic convert_strobe_prev_reg;
   logic convert_strobe_rise;
   logic convert_strobe_fall;
   logic [CNT_W-1:0] link_gray_reg;
   logic [CNT_W-1:0] cnt_meta_reg;
   logic [CNT_W-1:0] cnt_sync_reg;
   logic [CNT_W-1:0] cnt_bin;
   logic [RES_W-1:0] held_reg;
   logic [RES_W-1:0] result_reg;
   logic start_reg;
   logic out_bit;
   logic sdo_reg;
   logic sdo_oe_n_reg;
   logic powered_reg;
   logic track_reg;
   logic busy_reg;
   logic link_primed_reg;

   // ==========================================================
   // Link side: count falling shift edges within a frame.
   // The strobe high clears it with no shift edge needed, so the frame
   // always opens at the top bit even if the shift clock is parked.
   always_ff @(negedge i_sck or posedge i_convert_strobe)
   begin
      if (i_convert_strobe)
      begin
         link_gray_reg <= '0;
      end
      else if (gray2bin(link_gray_reg) != CNT_LAST)
      begin
         link_gray_reg <= bin2gray(gray2bin(link_gray_reg) + 4'h1);
      end
   end

   // ==========================================================
   // Crossings into the system clock: strobe level and gray bit index.
   // The strobe's asynchronous clear may jump several gray bits at once;
   // the pin is released a few cycles later and the host does not sample then.
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         convert_strobe_meta_reg <= 1'b0;
         convert_strobe_sync_reg <= 1'b0;
         convert_strobe_prev_reg <= 1'b0;
         cnt_meta_reg <= '0;
         cnt_sync_reg <= '0;
      end
      else if (i_ce)
      begin
         convert_strobe_meta_reg <= i_convert_strobe;
         convert_strobe_sync_reg <= convert_strobe_meta_reg;
         convert_strobe_prev_reg <= convert_strobe_sync_reg;
         cnt_meta_reg <= link_gray_reg;
         cnt_sync_reg <= cnt_meta_reg;
      end
   end

   assign convert_strobe_rise = convert_strobe_sync_reg && !convert_strobe_prev_reg;
   assign convert_strobe_fall = !convert_strobe_sync_reg && convert_strobe_prev_reg;
   assign cnt_bin = gray2bin(cnt_sync_reg);

   // ==========================================================
   // The link counter has no reset of its own and clears only while the strobe
   // is high, so the pin shows zero until a strobe has been seen since reset
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         link_primed_reg <= 1'b0;
      end
      else if (i_ce && convert_strobe_sync_reg)
      begin
         link_primed_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Converter sequence: acquire, convert, sleep
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_ACQ:
         begin
            if (convert_strobe_rise)
            begin
               state_next = ST_CONVERT_STROBE;
            end
         end
         ST_CONVERT_STROBE:
         begin
            if (sar_bus.done)
            begin
               state_next = ST_SLEEP;
            end
         end
         ST_SLEEP:
         begin
            if (!convert_strobe_sync_reg)
            begin
               state_next = ST_ACQ;
            end
         end
         default:
         begin
            state_next = ST_ACQ;
         end
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         state_reg <= ST_ACQ;
      end
      else if (i_ce)
      begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Sample capture and conversion start; the hold lasts through sleep
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         held_reg <= '0;
         start_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         start_reg <= (state_reg == ST_ACQ) && convert_strobe_rise;
         if ((state_reg == ST_ACQ) && convert_strobe_rise)
         begin
            held_reg <= i_ain_code;
         end
      end
   end

   assign sar_bus.start = start_reg;
   assign sar_bus.held = held_reg;

   sac_sar #(
      .STEP_CYC(STEP_CYC)
   ) u_sar (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .sar(sar_bus.eng)
   );

   // Result word kept until the next conversion ends
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         result_reg <= '0;
      end
      else if (i_ce && sar_bus.done)
      begin
         result_reg <= sar_bus.result;
      end
   end

   // ==========================================================
   // Serial output pin: top bit first, then zeros
   assign out_bit = (cnt_bin < CNT_LAST) ? result_reg[RES_W - 1 - int'(cnt_bin)] : 1'b0;

   // Synchronising costs about three system cycles of latency on release
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         sdo_reg <= 1'b0;
         sdo_oe_n_reg <= 1'b1;
      end
      else if (i_ce)
      begin
         sdo_oe_n_reg <= convert_strobe_sync_reg;
         sdo_reg <= (convert_strobe_sync_reg || !link_primed_reg) ? 1'b0 : out_bit;
      end
   end

   // Power and track-and-hold status; power drops once the result is in
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         powered_reg <= 1'b1;
         track_reg <= 1'b1;
         busy_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         powered_reg <= (state_next != ST_SLEEP);
         track_reg <= (state_next == ST_ACQ);
         busy_reg <= (state_next == ST_CONVERT_STROBE);
      end
   end

   assign o_serial_result_out = sdo_reg;
   assign o_serial_result_out_oe_n = sdo_oe_n_reg;
   assign o_powered = powered_reg;
   assign o_track = track_reg;
   assign o_busy = busy_reg;

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   a_rise_starts_convert_strobe: assert property (i_ce && convert_strobe_rise && state_reg == ST_ACQ |=> state_reg == ST_CONVERT_STROBE)
      else $error("Strobe rise did not start a conversion");
   a_done_sleeps: assert property (i_ce && sar_bus.done && state_reg == ST_CONVERT_STROBE |=> state_reg == ST_SLEEP)
      else $error("Converter did not enter sleep after conversion");
   a_start_busy: assert property (i_ce && start_reg |=> busy_reg && state_reg == ST_CONVERT_STROBE)
      else $error("Conversion start did not show busy");
   a_sleep_power_off: assert property (i_ce && sar_bus.done && convert_strobe_sync_reg |=> !powered_reg && state_reg == ST_SLEEP)
      else $error("Converter stayed powered after conversion");
   a_hiz_while_high: assert property (i_ce && convert_strobe_sync_reg |=> sdo_oe_n_reg)
      else $error("Serial output driven while strobe high");
   a_release_prompt: assert property ($rose(convert_strobe_sync_reg) && i_ce |=> sdo_oe_n_reg && !sdo_reg)
      else $error("Output not released after strobe rise");
   a_enable_on_fall: assert property ($fell(convert_strobe_sync_reg) && i_ce |=> !sdo_oe_n_reg)
      else $error("Output not enabled after strobe fall");
   a_top_bit_first: assert property (i_ce && !convert_strobe_sync_reg && cnt_bin == '0 |=> sdo_reg == result_reg[RES_W-1])
      else $error("Top result bit not presented first");
   a_zero_tail: assert property (i_ce && !convert_strobe_sync_reg && cnt_bin == CNT_LAST |=> sdo_reg == 1'b0 && !sdo_oe_n_reg)
      else $error("Trailing bit was not zero");
   a_steady_between: assert property (i_ce [*2] ##0 !convert_strobe_sync_reg && !$past(convert_strobe_sync_reg) && $stable(cnt_bin)
      && $stable(result_reg) |=> $stable(sdo_reg) || !i_ce)
      else $error("Output changed without a shift edge");
   a_restart_top: assert property ($rose(convert_strobe_sync_reg) && i_ce |-> ##[0:3] cnt_bin == '0)
      else $error("Bit index not restarted by strobe");
   a_hold_in_sleep: assert property (state_reg == ST_SLEEP && convert_strobe_sync_reg && i_ce |=> state_reg == ST_SLEEP
      && !track_reg)
      else $error("Left hold while strobe high");

   c_conversion: cover property (state_reg == ST_CONVERT_STROBE ##1 state_reg == ST_SLEEP);
   c_full_word: cover property (!convert_strobe_sync_reg && cnt_bin == CNT_LAST);
   c_early_fall: cover property (state_reg == ST_CONVERT_STROBE && convert_strobe_fall);
   c_sleep_exit: cover property (state_reg == ST_SLEEP ##1 state_reg == ST_ACQ);
   c_cut_frame: cover property (!convert_strobe_sync_reg && cnt_bin != '0 && cnt_bin != CNT_LAST ##1 convert_strobe_sync_reg);

endmodule

//--- rtl/sac_pkg.sv
/*
 * Shared constants, types and helpers for the serial converter readout block.
 * Assumes a 250 MHz system clock; all times are turned into cycles here.
 */
package sac_pkg;

   // ==========================================================
   // Widths
   localparam int RES_W = 12;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_LAST = 4'hC; // Bit index after the last result bit
   localparam logic [RES_W-1:0] TOP_BIT_MASK = 12'h800;

   // ==========================================================
   // Clock and conversion timing
   localparam int CLK_MHZ = 250;
   localparam int T_CONVERT_STROBE_SLOW_NS = 8000;
   localparam int T_CONVERT_STROBE_MID_NS = 3000;
   localparam int T_CONVERT_STROBE_FAST_NS = 1500;

   typedef enum logic [1:0] {GRADE_SLOW, GRADE_MID, GRADE_FAST} sac_grade_t;
   typedef enum logic [1:0] {ST_ACQ, ST_CONVERT_STROBE, ST_SLEEP} sac_state_t;

   // Least time rounds up to whole cycles, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   // Conversion length in cycles for a speed grade
   function automatic int convert_strobe_cycles(input sac_grade_t g);
      int c;
      c = ns_to_cyc(T_CONVERT_STROBE_FAST_NS);
      if (g == GRADE_SLOW)
      begin
         c = ns_to_cyc(T_CONVERT_STROBE_SLOW_NS);
      end
      else if (g == GRADE_MID)
      begin
         c = ns_to_cyc(T_CONVERT_STROBE_MID_NS);
      end
      return c;
   endfunction

   function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
      logic [CNT_W-1:0] b;
      b = '0;
      for (int i = CNT_W - 1; i >= 0; i--)
      begin
         b[i] = g[i] ^ ((i == CNT_W - 1) ? 1'b0 : b[i+1]);
      end
      return b;
   endfunction

endpackage

//--- rtl/sac_sar_if.sv
/*
 * Carrier between the conversion controller and the approximation engine.
 * Both ends sit on the system clock.
 */
`timescale 1ns/10ps
interface sac_sar_if;
   import sac_pkg::*;
   logic start;
   logic [RES_W-1:0] held;
   logic [RES_W-1:0] result;
   logic done;

   modport ctrl (output start, output held, input result, input done);
   modport eng (input start, input held, output result, output done);
endinterface

//--- rtl/sac_sar.sv
/*
 * Successive approximation engine: resolves one bit per step, top bit first.
 * Assumes the held code stays constant while a conversion runs.
 */
`timescale 1ns/10ps
module sac_sar
   import sac_pkg::*;
#(
   parameter int STEP_CYC = 31
)
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_ce,
   sac_sar_if.eng sar
);

   localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);

   logic [RES_W-1:0] trial_reg;
   logic [RES_W-1:0] bit_reg;
   logic [15:0] step_reg;
   logic busy_reg;
   logic [RES_W-1:0] result_reg;
   logic done_reg;

   // ==========================================================
   // Bit trial loop; a late start simply restarts the search
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         trial_reg <= '0;
         bit_reg <= '0;
         step_reg <= '0;
         busy_reg <= 1'b0;
         result_reg <= '0;
         done_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         done_reg <= 1'b0;
         if (sar.start)
         begin
            trial_reg <= TOP_BIT_MASK;
            bit_reg <= TOP_BIT_MASK;
            step_reg <= '0;
            busy_reg <= 1'b1;
         end
         else if (busy_reg && step_reg != STEP_LAST)
         begin
            step_reg <= step_reg + 16'h0001;
         end
         else if (busy_reg)
         begin
            step_reg <= '0;
            // Keep the trial bit only if the held level reaches it
            if (sar.held < trial_reg)
            begin
               trial_reg <= (trial_reg & ~bit_reg) | (bit_reg >> 1);
            end
            else
            begin
               trial_reg <= trial_reg | (bit_reg >> 1);
            end
            bit_reg <= bit_reg >> 1;
            if (bit_reg[0])
            begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
               result_reg <= (sar.held < trial_reg) ? (trial_reg & ~bit_reg) : trial_reg;
            end
         end
      end
   end

   assign sar.result = result_reg;
   assign sar.done = done_reg;

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   a_sar_exact_code: assert property (done_reg |-> result_reg == sar.held)
      else $error("Approximation did not settle on the held code");
   a_sar_one_shot: assert property (done_reg && i_ce |=> !done_reg)
      else $error("Done stood longer than one cycle");

endmodule

//--- testbench/sac_host_model.sv
/*
 * Serial host that sits across the three-wire link: raises the convert strobe, then reads bits.
 * Assumes the bench resolves the output pin level and feeds it back on i_sdo_wire.
 */
`timescale 1ns/10ps
module sac_host_model
(
   input wire logic i_sdo_wire,
   output logic o_sck,
   output logic o_convert_strobe
);
   // ==========================================================
   // Link timing
   localparam real HALF_SCK_NS = 62.5; // 8 MHz, below every grade limit
   localparam real MIN_CYCLE_NS = 2000.0; // Fast grade throughput floor
   localparam real SETUP_NS = 20.0; // Strobe fall to first rising shift edge
   real last_start;

   // Idle lines: shift clock stands still low between frames
   initial
   begin
      o_sck = 1'b0;
      o_convert_strobe = 1'b0;
      last_start = -MIN_CYCLE_NS;
   end

   // Start a conversion, never sooner than one full cycle after the last start
   task start_convert_strobe;
      while ($realtime - last_start < MIN_CYCLE_NS)
      begin
         #1;
      end
      last_start = $realtime;
      o_convert_strobe = 1'b1; // Held high until the bench sees the conversion end
   endtask

   // Shift pulses sent on purpose while the strobe is still high
   task stray_clocks(input int n);
      for (int k = 0; k < n; k++)
      begin
         #HALF_SCK_NS o_sck = 1'b1;
         #HALF_SCK_NS o_sck = 1'b0;
      end
   endtask

   // Lower the strobe and collect n bits, newest bit in the lsb
   task read_bits(input int n, output logic [31:0] bits);
      bits = '0;
      o_convert_strobe = 1'b0;
      #SETUP_NS;
      for (int k = 0; k < n; k++)
      begin
         o_sck = 1'b1;
         bits = {bits[30:0], i_sdo_wire}; // Sample on the rising edge
         #HALF_SCK_NS o_sck = 1'b0;
         #HALF_SCK_NS;
      end
   endtask
endmodule

//--- testbench/serial_adc_convert_readout_bench.sv
/*
 * Self-checking bench for the converter readout: conversions, frames, aborted frames.
 * Assumes the fast grade and a host model that owns the strobe and the shift clock.
 */
`timescale 1ns/10ps
module serial_adc_convert_readout_bench;
   import sac_pkg::*;
   logic i_mclk = 1'b0;
   logic i_srst = 1'b1;
   logic [RES_W-1:0] i_ain_code = 12'h000;
   logic sck, strobe, serial_result_out, oe_n, powered, track, busy;
   wire logic sdo_wire;
   int num_errors = 0;
   int checks = 0;
   logic [31:0] bits;

   // ==========================================================
   // Clock, pin level and instances
   always #2 i_mclk = ~i_mclk;
   assign sdo_wire = oe_n ? 1'bz : serial_result_out; // Active-low enable releases the pin

   sac_top #(.GRADE(GRADE_FAST)) dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(1'b1), .i_sck(sck),
      .i_convert_strobe(strobe), .i_ain_code(i_ain_code), .o_serial_result_out(serial_result_out),
      .o_serial_result_out_oe_n(oe_n), .o_powered(powered), .o_track(track), .o_busy(busy));
   sac_host_model host (.i_sdo_wire(sdo_wire), .o_sck(sck), .o_convert_strobe(strobe));

   // ==========================================================
   // Compare and report
   task check_bit(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask

   task check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task summarize;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Inputs change a fixed small delay after the rising edge
   task tick(input int n);
      repeat (n) @(posedge i_mclk);
      #0.5;
   endtask

   // A bounded wait that ran out ends the run
   task give_up(input int n, input int lim);
      if (n >= lim)
      begin
         num_errors++;
         $display("CHECK FAILED wait bound expected below %0d seen %0d", lim, n);
         summarize();
      end
   endtask

   // ==========================================================
   // Scenarios
   task test_reset;
      check_bit("oe_n", 1'b1, oe_n);
      check_bit("powered", 1'b1, powered);
      check_bit("track", 1'b1, track);
      check_bit("busy", 1'b0, busy);
      $display("test reset done");
   endtask

   // One conversion from strobe rise to sleep, with stray shift pulses meanwhile
   task do_convert_strobe(input logic [RES_W-1:0] code);
      int n;
      tick(1);
      i_ain_code = code;
      tick(1);
      host.start_convert_strobe();
      for (n = 0; n < 8 && oe_n !== 1'b1; n++) tick(1);
      give_up(n, 8);
      check_bit("released pin", 1'bz, sdo_wire);
      for (n = 0; n < 20 && busy !== 1'b1; n++) tick(1);
      give_up(n, 20);
      check_bit("busy", 1'b1, busy);
      check_bit("track", 1'b0, track);
      host.stray_clocks(3);
      for (n = 0; n < 500 && powered !== 1'b0; n++) tick(1);
      give_up(n, 500);
      check_bit("busy at sleep", 1'b0, busy);
      tick(30);
      check_bit("still asleep", 1'b0, powered);
      check_bit("pin while high", 1'bz, sdo_wire);
      i_ain_code = ~code; // Held sample must not follow the input
   endtask

   // Full frame of n bits: result first, then trailing zeros
   task test_frame(input logic [RES_W-1:0] code, input int n);
      do_convert_strobe(code);
      host.read_bits(n, bits);
      check_word("frame", {20'h00000, code} << (n - RES_W), bits);
      check_bit("pin driven", 1'b0, oe_n);
      $display("test frame %h of %0d bits done", code, n);
   endtask

   // Frame cut short by a new conversion, which must restart at the top bit
   task test_restart;
      do_convert_strobe(12'h3C6);
      host.read_bits(5, bits);
      check_word("partial frame", 32'h00000007, bits);
      do_convert_strobe(12'hC39);
      host.read_bits(RES_W, bits);
      check_word("restarted frame", 32'h00000C39, bits);
      $display("test restart done");
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      tick(3);
      test_reset();
      tick(1);
      i_srst = 1'b0;
      tick(4);
      test_frame(12'hA5C, 16);
      test_frame(12'hFFF, 13);
      test_frame(12'h000, 12);
      test_frame(12'h801, 14);
      test_restart();
      summarize();
   end
endmodule
